// ### rtl/cwu_params.svh
`ifndef CWU_PARAMS_SVH
`define CWU_PARAMS_SVH
// Register indexes; the byte address on the bus is four times the index
`define CWU_IDX_POL 12'h611
`define CWU_IDX_SHD 12'h612
`define CWU_IDX_SRC 12'h613
`define CWU_IDX_STR 12'h614
`define CWU_IDX_CTL 12'h615
`define CWU_IDX_IST 12'h616
`define CWU_IDX_IMSK 12'h617
`define CWU_ADDR_W 14
// Field positions
`define CWU_POL_IN_BIT 5
`define CWU_SHD_BIT 7
`define CWU_REN_BIT 6
`define CWU_SD_BD_LSB 4
`define CWU_SD_AC_LSB 2
`define CWU_CTL_EN_BIT 7
// Reset values
`define CWU_SHD_RST 8'h14
`define CWU_ZERO_RST 8'h00
`define CWU_CTL_RST 8'h00
// Shutdown source count and active-low source mask (pin, cmp1, cmp2)
`define CWU_NSRC 6
`define CWU_SRC_LOWACT 6'h31
`endif

// ### rtl/cwu_pkg.sv
package cwu_pkg;
   typedef enum logic [1:0] {
      CWU_SD_INACTIVE = 2'b00,
      CWU_SD_TRISTATE = 2'b01,
      CWU_SD_LOW = 2'b10,
      CWU_SD_HIGH = 2'b11
   } cwu_sd_state_t;
   typedef enum logic [2:0] {
      CWU_M_ASTEER = 3'b000,
      CWU_M_SSTEER = 3'b001,
      CWU_M_FFWD = 3'b010,
      CWU_M_FREV = 3'b011,
      CWU_M_HALF = 3'b100,
      CWU_M_PUSH = 3'b101
   } cwu_mode_t;
   typedef struct packed {
      logic [3:0] val;
      logic [3:0] oe;
   } cwu_pins_t;
   typedef enum logic [1:0] {
      CWU_RUN = 2'b00,
      CWU_SHUT = 2'b01,
      CWU_WAIT_RISE = 2'b10
   } cwu_state_t;
endpackage

// ### rtl/cwu_sync2.sv
`timescale 1ns/1ps
module cwu_sync2 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic ce,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= '0;
         q <= '0;
      end else if (ce) begin
         s1_q <= d;
         q <= s1_q;
      end
   end
endmodule

// ### rtl/cwu_out_stage.sv
`timescale 1ns/1ps
module cwu_out_stage
   import cwu_pkg::*;
(
   input wire logic data_in,
   input wire logic steer_mode,
   input wire logic steer_en,
   input wire logic override_val,
   input wire logic invert,
   input wire logic shut,
   input wire cwu_sd_state_t sd_state,
   output logic pin_val,
   output logic pin_oe
);
   always_comb begin
      pin_oe = 1'b1;
      if (shut) begin
         case (sd_state)
            CWU_SD_HIGH: pin_val = 1'b1;
            CWU_SD_LOW: pin_val = 1'b0;
            CWU_SD_TRISTATE: begin
               pin_val = 1'b0;
               pin_oe = 1'b0;
            end
            // Inactive level with polarity; dead band is outside this block
            default: pin_val = invert;
         endcase
      end else if (steer_mode && !steer_en) begin
         pin_val = override_val;
      end else begin
         pin_val = data_in ^ invert;
      end
   end
endmodule

// ### rtl/cwu_top.sv
`timescale 1ns/1ps
`include "cwu_params.svh"
module cwu_top
   import cwu_pkg::*;
#(
   parameter int NSRC = `CWU_NSRC
) (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic CE,
   input wire logic [`CWU_ADDR_W-1:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [`CWU_ADDR_W-1:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   input wire logic DATA_IN,
   input wire logic [NSRC-1:0] SHUTDOWN_SRC,
   output cwu_pins_t OUT_PINS,
   output logic IRQ
);
   localparam logic [NSRC-1:0] LOWACT = NSRC'(`CWU_SRC_LOWACT);

   logic data_s;
   logic [NSRC-1:0] src_s;
   cwu_sync2 #(.W(1)) u_sync_data (
      .clk(CLK), .ce(CE), .rst(RESET), .d(DATA_IN), .q(data_s)
   );
   cwu_sync2 #(.W(NSRC)) u_sync_src (
      .clk(CLK), .ce(CE), .rst(RESET), .d(SHUTDOWN_SRC), .q(src_s)
   );

   // Registers
   logic [3:0] pol_q;
   logic shd_q;
   logic ren_q;
   logic [1:0] sd_bd_q;
   logic [1:0] sd_ac_q;
   logic [NSRC-1:0] src_en_q;
   logic [3:0] ovr_q;
   logic [3:0] str_q;
   logic [3:0] str_act_q;
   logic en_q;
   logic [2:0] mode_q;
   logic [1:0] ist_q;
   logic [1:0] imsk_q;
   logic data_d1_q;
   logic hold_q;

   // AXI write channel
   logic aw_held_q;
   logic w_held_q;
   logic [`CWU_ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_fire;
   logic [11:0] wr_idx;
   logic wr_ok;
   logic [7:0] wb;

   // Ready drops with the clock enable, so no beat is offered that would not be taken
   assign AWREADY = CE && !aw_held_q && !BVALID;
   assign WREADY = CE && !w_held_q && !BVALID;
   assign wr_fire = aw_held_q && w_held_q && !BVALID;
   assign wr_idx = 12'(awaddr_q[`CWU_ADDR_W-1:2]);
   assign wb = wdata_q[7:0];
   assign wr_ok = wstrb_q[0] && (awaddr_q[1:0] == 2'h0);

   always_ff @(posedge CLK) begin
      if (RESET) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         BVALID <= 1'b0;
         BRESP <= 2'h0;
      end else if (CE) begin
         if (AWVALID && AWREADY) begin
            aw_held_q <= 1'b1;
            awaddr_q <= AWADDR;
         end
         if (WVALID && WREADY) begin
            w_held_q <= 1'b1;
            wdata_q <= WDATA;
            wstrb_q <= WSTRB;
         end
         if (wr_fire) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            BVALID <= 1'b1;
            BRESP <= (wr_idx >= `CWU_IDX_POL && wr_idx <= `CWU_IDX_IMSK) ? 2'h0 : 2'h2;
         end else if (BVALID && BREADY) begin
            BVALID <= 1'b0;
         end
      end
   end

   function automatic logic wr_to(input logic [11:0] idx);
      return wr_fire && wr_ok && (wr_idx == idx);
   endfunction

   // Plain configuration registers
   always_ff @(posedge CLK) begin
      if (RESET) begin
         pol_q <= 4'h0;
         ren_q <= 1'b0;
         sd_bd_q <= 2'(`CWU_SHD_RST >> `CWU_SD_BD_LSB);
         sd_ac_q <= 2'(`CWU_SHD_RST >> `CWU_SD_AC_LSB);
         src_en_q <= '0;
         ovr_q <= 4'h0;
         str_q <= 4'h0;
         en_q <= 1'b0;
         mode_q <= 3'h0;
         imsk_q <= 2'h0;
      end else if (CE) begin
         if (wr_to(`CWU_IDX_POL)) begin
            pol_q <= wb[3:0];
         end
         if (wr_to(`CWU_IDX_SHD)) begin
            ren_q <= wb[`CWU_REN_BIT];
            sd_bd_q <= wb[`CWU_SD_BD_LSB +: 2];
            sd_ac_q <= wb[`CWU_SD_AC_LSB +: 2];
         end
         if (wr_to(`CWU_IDX_SRC)) begin
            src_en_q <= wb[NSRC-1:0];
         end
         if (wr_to(`CWU_IDX_STR)) begin
            ovr_q <= wb[7:4];
            str_q <= wb[3:0];
         end
         if (wr_to(`CWU_IDX_CTL)) begin
            en_q <= wb[`CWU_CTL_EN_BIT];
            mode_q <= wb[2:0];
         end
         if (wr_to(`CWU_IDX_IMSK)) begin
            imsk_q <= wb[1:0];
         end
      end
   end

   // Shutdown sources: timers high-active, pin and comparators low-active
   logic [NSRC-1:0] src_hit;
   logic src_any;
   logic data_rise;
   assign src_hit = src_en_q & (src_s ^ LOWACT);
   assign src_any = |src_hit;
   assign data_rise = data_s && !data_d1_q;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         data_d1_q <= 1'b0;
      end else if (CE) begin
         data_d1_q <= data_s;
      end
   end

   // Shutdown status: hardware set wins over any clear
   always_ff @(posedge CLK) begin
      if (RESET) begin
         shd_q <= 1'b0;
      end else if (CE) begin
         if (en_q && src_any) begin
            shd_q <= 1'b1;
         end else if (wr_to(`CWU_IDX_SHD) && (!en_q || !wb[`CWU_SHD_BIT])) begin
            shd_q <= wb[`CWU_SHD_BIT];
         end else if (ren_q && !src_any) begin
            shd_q <= 1'b0;
         end
      end
   end

   // Outputs stay shut after the bit clears until a data rising edge
   always_ff @(posedge CLK) begin
      if (RESET) begin
         hold_q <= 1'b0;
      end else if (CE) begin
         if (shd_q) begin
            hold_q <= 1'b1;
         end else if (data_rise) begin
            hold_q <= 1'b0;
         end
      end
   end

   // Synchronous steering loads new enables on the data rising edge
   always_ff @(posedge CLK) begin
      if (RESET) begin
         str_act_q <= 4'h0;
      end else if (CE) begin
         if (mode_q != CWU_M_SSTEER || data_rise) begin
            str_act_q <= str_q;
         end
      end
   end

   // Events: bit0 shutdown entered, bit1 shutdown released
   logic shd_d1_q;
   always_ff @(posedge CLK) begin
      if (RESET) begin
         shd_d1_q <= 1'b0;
      end else if (CE) begin
         shd_d1_q <= shd_q;
      end
   end

   logic [1:0] ev;
   assign ev = {shd_d1_q && !shd_q, shd_q && !shd_d1_q};

   always_ff @(posedge CLK) begin
      if (RESET) begin
         ist_q <= 2'h0;
      end else if (CE) begin
         if (wr_to(`CWU_IDX_IST)) begin
            ist_q <= (ist_q & ~wb[1:0]) | ev;
         end else begin
            ist_q <= ist_q | ev;
         end
      end
   end
   assign IRQ = |(ist_q & imsk_q);

   // Output stages
   logic shut;
   logic steer_mode;
   assign shut = shd_q || hold_q;
   assign steer_mode = (mode_q[2:1] == 2'b00);

   cwu_pins_t pins_c;
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_out
         // Outputs A and C use the A/C field, B and D the B/D field
         cwu_out_stage u_out (
            .data_in(data_s),
            .steer_mode(steer_mode),
            .steer_en(str_act_q[g]),
            .override_val(ovr_q[g]),
            .invert(pol_q[g]),
            .shut(shut),
            .sd_state(cwu_sd_state_t'((g % 2 == 1) ? sd_bd_q : sd_ac_q)),
            .pin_val(pins_c.val[g]),
            .pin_oe(pins_c.oe[g])
         );
      end
   endgenerate

   // Disabled unit drives nothing unless shutdown or the post-shutdown hold is in force
   always_ff @(posedge CLK) begin
      if (RESET) begin
         OUT_PINS <= '0;
      end else if (CE) begin
         if (en_q || shut) begin
            OUT_PINS <= pins_c;
         end else begin
            OUT_PINS <= '0;
         end
      end
   end

   // AXI read channel
   logic [11:0] rd_idx;
   logic [7:0] rd_byte;
   assign rd_idx = 12'(ARADDR[`CWU_ADDR_W-1:2]);
   assign ARREADY = CE && !RVALID;

   always_comb begin
      case (rd_idx)
         `CWU_IDX_POL: rd_byte = {2'b00, data_s, 1'b0, pol_q};
         `CWU_IDX_SHD: rd_byte = {shd_q, ren_q, sd_bd_q, sd_ac_q, 2'b00};
         `CWU_IDX_SRC: rd_byte = 8'(src_en_q);
         `CWU_IDX_STR: rd_byte = {ovr_q, str_q};
         `CWU_IDX_CTL: rd_byte = {en_q, 4'h0, mode_q};
         `CWU_IDX_IST: rd_byte = {6'h00, ist_q};
         `CWU_IDX_IMSK: rd_byte = {6'h00, imsk_q};
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         RVALID <= 1'b0;
         RDATA <= 32'h0;
         RRESP <= 2'h0;
      end else if (CE) begin
         if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            RDATA <= {24'h000000, rd_byte};
            RRESP <= (rd_idx >= `CWU_IDX_POL && rd_idx <= `CWU_IDX_IMSK) ? 2'h0 : 2'h2;
         end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
         end
      end
   end

   // Checks
   shd_hw_set_a: assert property (@(posedge CLK) disable iff (RESET)
      CE && en_q && src_any |=> shd_q)
      else $error("shutdown not set by source");
   shd_restart_a: assert property (@(posedge CLK) disable iff (RESET)
      CE && shd_q && !ren_q && !wr_to(`CWU_IDX_SHD) |=> shd_q)
      else $error("shutdown cleared without restart");
   shd_hold_a: assert property (@(posedge CLK) disable iff (RESET)
      CE && $fell(shd_q) && !data_rise |-> hold_q)
      else $error("outputs released before rising edge");
   steer_buf_a: assert property (@(posedge CLK) disable iff (RESET)
      CE && mode_q == CWU_M_SSTEER && !data_rise |=> $stable(str_act_q))
      else $error("steering changed without edge");
   sd_high_a: assert property (@(posedge CLK) disable iff (RESET)
      CE && shut && sd_ac_q == 2'b11 |=> OUT_PINS.val[0] || !CE)
      else $error("A not high in shutdown");
   sd_tri_a: assert property (@(posedge CLK) disable iff (RESET)
      CE && shut && sd_bd_q == 2'b01 |=> !OUT_PINS.oe[1] || !CE)
      else $error("B not tristated");
   in_level_a: assert property (@(posedge CLK) disable iff (RESET)
      ARVALID && ARREADY && CE && rd_idx == `CWU_IDX_POL |=> RDATA[`CWU_POL_IN_BIT] == $past(data_s))
      else $error("input level readback wrong");
   src_mask_a: assert property (@(posedge CLK) disable iff (RESET)
      src_en_q == '0 |-> !src_any)
      else $error("disabled source hit");
   irq_a: assert property (@(posedge CLK) disable iff (RESET)
      CE && $rose(shd_q) |=> ist_q[0] && (IRQ || !imsk_q[0]))
      else $error("shutdown event not flagged");
endmodule

// ### dv/cwu_switch_model.sv
`timescale 1ns/1ps
module cwu_switch_model
   import cwu_pkg::*;
(
   input wire cwu_pins_t pins,
   output logic [3:0] gate_lvl
);
   // Driver inputs carry pull-downs, so a released pin settles low instead of keeping its last value
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         gate_lvl[i] = pins.oe[i] ? pins.val[i] : 1'b0;
      end
   end
endmodule

// ### dv/tb_complementary_output_control.sv
`timescale 1ns/1ps
`include "cwu_params.svh"
module tb_complementary_output_control
   import cwu_pkg::*;
;
   typedef struct packed {
      logic [3:0] pol;
      logic [7:0] str;
      logic din;
      logic [7:0] exp;
   } cwu_row_t;
   logic CLK, RESET, CE, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
   logic ARVALID, ARREADY, RVALID, RREADY, DATA_IN, IRQ;
   logic [`CWU_ADDR_W-1:0] AWADDR, ARADDR;
   logic [31:0] WDATA, RDATA, rd;
   logic [3:0] WSTRB, gate_lvl;
   logic [1:0] BRESP, RRESP, rr, br, c;
   logic [5:0] SHUTDOWN_SRC;
   cwu_pins_t OUT_PINS;
   int mismatches, n_compared;
   cwu_row_t rows [5] = '{'{4'h0, 8'h0F, 1'b1, 8'hFF}, '{4'h5, 8'h0F, 1'b1, 8'hAF},
      '{4'h5, 8'h0F, 1'b0, 8'h5F}, '{4'hF, 8'hA0, 1'b1, 8'hAF}, '{4'h3, 8'h53, 1'b1, 8'h4F}};
   logic [7:0] sd_exp [4] = '{8'h5F, 8'h00, 8'h0F, 8'hFF};
   logic [7:0] rst_exp [7] = '{8'h00, `CWU_SHD_RST, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   cwu_top #(.NSRC(`CWU_NSRC)) dut (.CLK(CLK), .RESET(RESET), .CE(CE), .AWADDR(AWADDR),
      .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
      .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
      .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
      .RREADY(RREADY), .DATA_IN(DATA_IN), .SHUTDOWN_SRC(SHUTDOWN_SRC), .OUT_PINS(OUT_PINS),
      .IRQ(IRQ));
   cwu_switch_model sw (.pins(OUT_PINS), .gate_lvl(gate_lvl));

   initial begin
      CLK = 1'b0;
      forever #50 CLK = ~CLK;
   end

   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic tmo();
      mismatches++;
      results();
   endtask
   task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_pin(input logic [7:0] exp);
      cmp_val({24'h0, gate_lvl, OUT_PINS.oe}, {24'h0, exp});
   endtask
   task automatic settle();
      repeat (6) @(posedge CLK);
   endtask
   // Address and data are offered together; either may be taken first
   task automatic axw(input logic [11:0] idx, input logic [7:0] d);
      logic aw, w;
      int n;
      aw = 1'b0;
      w = 1'b0;
      AWADDR <= {idx, 2'b00};
      WDATA <= {24'h0, d};
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      for (n = 0; n < 50 && !(aw && w); n++) begin
         @(posedge CLK);
         if (!aw && AWREADY === 1'b1) begin
            aw = 1'b1;
            AWVALID <= 1'b0;
         end
         if (!w && WREADY === 1'b1) begin
            w = 1'b1;
            WVALID <= 1'b0;
         end
      end
      if (!(aw && w)) tmo();
      n = 0;
      do begin
         @(posedge CLK);
         n++;
      end while (BVALID !== 1'b1 && n < 50);
      if (BVALID !== 1'b1) tmo();
      br = BRESP;
   endtask
   task automatic axr(input logic [11:0] idx);
      int n;
      ARADDR <= {idx, 2'b00};
      ARVALID <= 1'b1;
      n = 0;
      do begin
         @(posedge CLK);
         n++;
      end while (ARREADY !== 1'b1 && n < 50);
      ARVALID <= 1'b0;
      do begin
         @(posedge CLK);
         n++;
      end while (RVALID !== 1'b1 && n < 100);
      if (RVALID !== 1'b1) tmo();
      rd = RDATA;
      rr = RRESP;
   endtask
   task automatic chk_reg(input logic [11:0] idx, input logic [7:0] exp);
      axr(idx);
      cmp_val(rd, {24'h0, exp});
   endtask

   initial begin
      RESET = 1'b1;
      CE = 1'b1;
      AWADDR = '0;
      ARADDR = '0;
      WDATA = 32'h0;
      WSTRB = 4'hF;
      AWVALID = 1'b0;
      WVALID = 1'b0;
      ARVALID = 1'b0;
      // Ready lines stay high so a response is taken the edge it appears
      BREADY = 1'b1;
      RREADY = 1'b1;
      DATA_IN = 1'b0;
      SHUTDOWN_SRC = `CWU_SRC_LOWACT;
      mismatches = 0;
      n_compared = 0;
      repeat (3) @(posedge CLK);
      cmp_pin(8'h00);
      cmp_val({31'h0, IRQ}, 32'h0);
      RESET <= 1'b0;
      @(posedge CLK);
      for (int i = 0; i < 7; i++) begin
         chk_reg(12'(`CWU_IDX_POL + i), rst_exp[i]);
      end
      axr(12'h618);
      cmp_val(rd, 32'h0);
      cmp_val({30'h0, rr}, 32'h2);
      axw(12'h618, 8'h55);
      cmp_val({30'h0, br}, 32'h2);
      // A write without the low byte lane enabled must leave the register alone
      WSTRB <= 4'hE;
      axw(`CWU_IDX_SRC, 8'h3F);
      WSTRB <= 4'hF;
      chk_reg(`CWU_IDX_SRC, 8'h00);
      axw(`CWU_IDX_CTL, 8'h80);
      cmp_val({30'h0, br}, 32'h0);
      foreach (rows[i]) begin
         axw(`CWU_IDX_POL, {4'h0, rows[i].pol});
         axw(`CWU_IDX_STR, rows[i].str);
         DATA_IN <= rows[i].din;
         settle();
         cmp_pin(rows[i].exp);
         chk_reg(`CWU_IDX_POL, {2'b00, rows[i].din, 1'b0, rows[i].pol});
      end
      axw(`CWU_IDX_POL, 8'h00);
      axw(`CWU_IDX_STR, 8'hF0);
      axw(`CWU_IDX_CTL, 8'h81);
      settle();
      cmp_pin(8'hFF);
      axw(`CWU_IDX_STR, 8'h0F);
      settle();
      cmp_pin(8'h0F);
      DATA_IN <= 1'b0;
      settle();
      DATA_IN <= 1'b1;
      settle();
      cmp_pin(8'hFF);
      // Half-bridge mode: steering bits cleared must not force the overrides
      axw(`CWU_IDX_CTL, 8'h84);
      axw(`CWU_IDX_STR, 8'h00);
      settle();
      cmp_pin(8'hFF);
      axw(`CWU_IDX_CTL, 8'h80);
      axw(`CWU_IDX_STR, 8'hF0);
      axw(`CWU_IDX_POL, 8'h05);
      for (int i = 0; i < 6; i++) begin
         c = 2'(i);
         DATA_IN <= 1'b0;
         axw(`CWU_IDX_SHD, {2'b00, c, c, 2'b00});
         axw(`CWU_IDX_SRC, 8'h3F & ~8'(8'h01 << i));
         SHUTDOWN_SRC <= `CWU_SRC_LOWACT ^ 6'(6'h01 << i);
         settle();
         cmp_pin(8'hFF);
         axw(`CWU_IDX_SRC, 8'(8'h01 << i));
         settle();
         cmp_pin(sd_exp[c]);
         chk_reg(`CWU_IDX_SHD, {2'b10, c, c, 2'b00});
         SHUTDOWN_SRC <= `CWU_SRC_LOWACT;
         settle();
         chk_reg(`CWU_IDX_SHD, {2'b10, c, c, 2'b00});
         axw(`CWU_IDX_SHD, {2'b00, c, c, 2'b00});
         settle();
         cmp_pin(sd_exp[c]);
         DATA_IN <= 1'b1;
         settle();
         cmp_pin(8'hFF);
      end
      DATA_IN <= 1'b0;
      axw(`CWU_IDX_IST, 8'h03);
      axw(`CWU_IDX_IMSK, 8'h00);
      axw(`CWU_IDX_SHD, 8'h68);
      axw(`CWU_IDX_SRC, 8'h02);
      SHUTDOWN_SRC <= `CWU_SRC_LOWACT ^ 6'h02;
      settle();
      cmp_pin(8'h0F);
      cmp_val({31'h0, IRQ}, 32'h0);
      chk_reg(`CWU_IDX_IST, 8'h01);
      axw(`CWU_IDX_IMSK, 8'h01);
      cmp_val({31'h0, IRQ}, 32'h1);
      axw(`CWU_IDX_IST, 8'h01);
      cmp_val({31'h0, IRQ}, 32'h0);
      SHUTDOWN_SRC <= `CWU_SRC_LOWACT;
      settle();
      chk_reg(`CWU_IDX_SHD, 8'h68);
      chk_reg(`CWU_IDX_IST, 8'h02);
      cmp_pin(8'h0F);
      DATA_IN <= 1'b1;
      settle();
      cmp_pin(8'hFF);
      axw(`CWU_IDX_CTL, 8'h00);
      settle();
      cmp_pin(8'h00);
      axw(`CWU_IDX_SHD, 8'hBC);
      settle();
      cmp_pin(8'hFF);
      chk_reg(`CWU_IDX_SHD, 8'hBC);
      DATA_IN <= 1'b0;
      axw(`CWU_IDX_SHD, 8'h3C);
      settle();
      cmp_pin(8'hFF);
      // Frozen by the clock enable: the data edge must not release the hold
      CE <= 1'b0;
      DATA_IN <= 1'b1;
      settle();
      cmp_pin(8'hFF);
      // Reset acts even while the clock enable is low
      RESET <= 1'b1;
      repeat (2) @(posedge CLK);
      cmp_pin(8'h00);
      RESET <= 1'b0;
      CE <= 1'b1;
      @(posedge CLK);
      chk_reg(`CWU_IDX_SHD, `CWU_SHD_RST);
      chk_reg(`CWU_IDX_STR, 8'h00);
      results();
   end
endmodule
